// file: src/cfg_pkg.sv
// constants for the warm-boot reconfiguration control block
package cfg_pkg;
  // configuration word stream
  localparam logic [31:0] SYNC_WORD     = 32'hAA995566;
  localparam int          HDR_TYPE_MSB  = 31;
  localparam int          HDR_TYPE_LSB  = 29;
  localparam int          HDR_OP_MSB    = 28;
  localparam int          HDR_OP_LSB    = 27;
  localparam int          HDR_ADDR_MSB  = 26;
  localparam int          HDR_ADDR_LSB  = 13;
  localparam int          HDR_CNT_MSB   = 10;
  localparam logic [2:0]  HDR_TYPE1     = 3'h1;
  localparam logic [1:0]  OP_READ       = 2'h1;
  localparam logic [1:0]  OP_WRITE      = 2'h2;
  localparam logic [10:0] CNT_ONE       = 11'h001;
  localparam int          CMD_MSB       = 4;
  // register addresses
  localparam logic [13:0] REG_CMD       = 14'h0004;
  localparam logic [13:0] REG_WARM      = 14'h0010;
  localparam logic [13:0] REG_TIMER     = 14'h0011;
  localparam logic [13:0] REG_HIST      = 14'h0016;
  // command codes
  localparam logic [4:0]  CMD_REPROG    = 5'h0F;
  localparam logic [4:0]  CMD_DESYNC    = 5'h0D;
  localparam logic [4:0]  CMD_RELOAD    = 5'h11;
  // warm_start_address fields
  localparam int          RS_MSB        = 31;
  localparam int          RS_LSB        = 30;
  localparam int          START_MSB     = 28;
  localparam int          SPI_START_MSB = 23;
  // timer register fields
  localparam int          TMR_VAL_MSB   = 29;
  localparam int          TMR_CFG_MON   = 30;
  localparam int          TMR_USR_MON   = 31;
  // boot history entry layout
  localparam int          ENTRY_W       = 8;
  localparam int          H_VALID       = 0;
  localparam int          H_FALLBACK    = 1;
  localparam int          H_REPROG      = 2;
  localparam int          H_WTO         = 3;
  localparam int          H_ID          = 4;
  localparam int          H_CRC         = 5;
  localparam int          H_WRAP        = 6;
  // configuration mode straps
  localparam logic [2:0]  MODE_MSERIAL  = 3'h0;
  localparam logic [2:0]  MODE_SPI      = 3'h1;
  localparam logic [2:0]  MODE_BPI      = 3'h2;
  localparam logic [2:0]  MODE_MPAR     = 3'h4;
  // spi address framing: 24 address bits then an undefined low byte
  localparam int          SPI_BITS      = 32;
  localparam logic [7:0]  SPI_LOW_FILL  = 8'hFF;
  localparam logic [5:0]  SPI_CNT_LAST  = 6'h1F;
  // watchdog time base: oscillator divided by 256, emulated on clk
  localparam int          CLK_KHZ       = 40000;
  localparam int          OSC_KHZ       = 65000;
  localparam int          OSC_DIV       = 256;
  localparam int          TICK_CYC      = OSC_DIV * CLK_KHZ / OSC_KHZ;
  localparam int          WDOG_W        = 30;
endpackage

// file: src/warm_boot_reconfig_control.sv
// warm-boot reconfiguration controller: word parser, boot history, fallback
`timescale 1ns/1ps
`default_nettype none
module warm_boot_reconfig_control (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // configuration word port
  input  wire logic        cfgWrite,
  input  wire logic [31:0] cfgWord,
  output logic             rdValid,
  output logic [31:0]      rdData,
  // mode straps from pins
  input  wire logic [2:0]  modePins,
  // configuration engine status
  input  wire logic        memCleared,
  input  wire logic        loadOk,
  input  wire logic        wrapFault,
  input  wire logic        crcFault,
  input  wire logic        idFault,
  output logic             loadStart,
  // device pins
  output logic             initFlagPin,
  output logic             doneOut,
  output logic [1:0]       revSelOut,
  output logic             revSelOe,
  output logic [28:0]      flashAddrOut,
  output logic             flashAddrOe,
  output logic             spiAddrBit,
  output logic             spiAddrEn
);
  typedef enum logic [4:0] {
    C_CLEAR = 5'h01, C_APPLY = 5'h02, C_LOAD = 5'h04, C_USER = 5'h08, C_FAIL = 5'h10
  } cfg_state_t;
  typedef enum logic [2:0] {P_UNSYNC = 3'h1, P_HDR = 3'h2, P_DATA = 3'h4} parse_state_t;

  // undo the per-byte bit reversal of the port
  function automatic logic [31:0] byteSwap(input logic [31:0] w);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      r[i] = w[(i / 8) * 8 + 7 - (i % 8)];
    end
    return r;
  endfunction

  wdog_if wd ();

  cfg_state_t                   state_r;
  parse_state_t                 pState_r;
  logic [2:0]                   modeMeta_r;
  logic [2:0]                   mode_r;
  logic [31:0]                  word;
  logic [13:0]                  regAddr_r;
  logic [31:0]                  warmAddr_r;
  logic [31:0]                  timer_r;
  logic [2*cfg_pkg::ENTRY_W-1:0] history_r;
  logic [cfg_pkg::ENTRY_W-1:0]  entry;
  logic                         fallback_r;
  logic                         warm_r;
  logic                         wdLock_r;
  logic                         iprogSeen_r;
  logic                         wtoSeen_r;
  logic [31:0]                  spiShift_r;
  logic [5:0]                   spiCnt_r;
  logic                         dataWr;
  logic                         cmdWr;
  logic                         reprogCmd;
  logic                         reprogTake;
  logic                         loadFail;
  logic                         record;
  logic                         isSpi;
  logic                         isFlashPar;

  // mode straps come from pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      modeMeta_r <= 3'h0;
      mode_r     <= 3'h0;
    end else begin
      modeMeta_r <= modePins;
      mode_r     <= modeMeta_r;
    end
  end

  assign isSpi      = (mode_r == cfg_pkg::MODE_SPI);
  assign isFlashPar = (mode_r == cfg_pkg::MODE_BPI);
  assign word       = byteSwap(cfgWord);

  // packet parser: sync, type-1 header, one data word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pState_r  <= P_UNSYNC;
      regAddr_r <= 14'h0000;
    end else if (reprogTake) begin
      pState_r <= P_UNSYNC;
    end else if (cfgWrite) begin
      case (pState_r)
        P_UNSYNC: begin
          if (word == cfg_pkg::SYNC_WORD) begin
            pState_r <= P_HDR;
          end
        end
        P_HDR: begin
          if (word[cfg_pkg::HDR_TYPE_MSB:cfg_pkg::HDR_TYPE_LSB] == cfg_pkg::HDR_TYPE1 &&
              word[cfg_pkg::HDR_OP_MSB:cfg_pkg::HDR_OP_LSB] == cfg_pkg::OP_WRITE &&
              word[cfg_pkg::HDR_CNT_MSB:0] == cfg_pkg::CNT_ONE) begin
            regAddr_r <= word[cfg_pkg::HDR_ADDR_MSB:cfg_pkg::HDR_ADDR_LSB];
            pState_r  <= P_DATA;
          end
        end
        P_DATA: begin
          pState_r <= (cmdWr && word[cfg_pkg::CMD_MSB:0] == cfg_pkg::CMD_DESYNC) ?
                      P_UNSYNC : P_HDR;
        end
        default: pState_r <= P_UNSYNC;
      endcase
    end
  end

  assign dataWr    = cfgWrite && (pState_r == P_DATA);
  assign cmdWr     = dataWr && (regAddr_r == cfg_pkg::REG_CMD);
  assign reprogCmd = cmdWr && (word[cfg_pkg::CMD_MSB:0] == cfg_pkg::CMD_REPROG);
  // skipped while the safe image is loading
  assign reprogTake = reprogCmd && !fallback_r &&
                      (state_r == C_USER || state_r == C_LOAD);

  // register reads answer one cycle after the read header
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdValid <= 1'b0;
      rdData  <= 32'h00000000;
    end else begin
      rdValid <= 1'b0;
      if (cfgWrite && pState_r == P_HDR &&
          word[cfg_pkg::HDR_TYPE_MSB:cfg_pkg::HDR_TYPE_LSB] == cfg_pkg::HDR_TYPE1 &&
          word[cfg_pkg::HDR_OP_MSB:cfg_pkg::HDR_OP_LSB] == cfg_pkg::OP_READ) begin
        rdValid <= 1'b1;
        if (word[cfg_pkg::HDR_ADDR_MSB:cfg_pkg::HDR_ADDR_LSB] == cfg_pkg::REG_HIST) begin
          rdData <= byteSwap({16'h0000, history_r});
        end else if (word[cfg_pkg::HDR_ADDR_MSB:cfg_pkg::HDR_ADDR_LSB] == cfg_pkg::REG_WARM) begin
          rdData <= byteSwap(warmAddr_r);
        end else begin
          rdData <= 32'h00000000;
        end
      end
    end
  end

  // warm address and timer survive a reprogram
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      warmAddr_r <= 32'h00000000;
      timer_r    <= 32'h00000000;
    end else if (dataWr && regAddr_r == cfg_pkg::REG_WARM) begin
      warmAddr_r <= word;
    end else if (dataWr && regAddr_r == cfg_pkg::REG_TIMER) begin
      timer_r <= word;
    end
  end

  // main configuration sequence
  assign loadFail = (state_r == C_LOAD) && (wrapFault || crcFault || idFault) ||
                    wd.expired;
  assign record   = (state_r == C_LOAD && loadOk) || loadFail;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r    <= C_CLEAR;
      fallback_r <= 1'b0;
      warm_r     <= 1'b0;
      wdLock_r   <= 1'b0;
    end else begin
      case (state_r)
        C_CLEAR: begin
          if (memCleared) begin
            state_r <= C_APPLY;
          end
        end
        C_APPLY, C_LOAD, C_USER: begin
          if (loadFail && fallback_r) begin
            state_r <= C_FAIL;
          end else if (loadFail) begin
            state_r    <= C_CLEAR;
            fallback_r <= 1'b1;
            warm_r     <= 1'b0;
            wdLock_r   <= 1'b1;
          end else if (reprogTake) begin
            state_r <= C_CLEAR;
            warm_r  <= 1'b1;
          end else if (state_r == C_LOAD && loadOk) begin
            state_r    <= C_USER;
            fallback_r <= 1'b0;
            if (warm_r) begin
              wdLock_r <= 1'b0;
            end
          end else if (state_r == C_APPLY &&
                       (!isSpi || spiCnt_r == cfg_pkg::SPI_CNT_LAST)) begin
            state_r <= C_LOAD;
          end
        end
        C_FAIL: state_r <= C_FAIL;
        default: state_r <= C_CLEAR;
      endcase
    end
  end

  // spi start address: 24 bits then the undefined low byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      spiShift_r <= 32'h00000000;
      spiCnt_r   <= 6'h00;
    end else if (state_r == C_APPLY && isSpi) begin
      spiShift_r <= {spiShift_r[30:0], 1'b0};
      spiCnt_r   <= spiCnt_r + 6'h01;
    end else begin
      spiShift_r <= warm_r ? {warmAddr_r[cfg_pkg::SPI_START_MSB:0], cfg_pkg::SPI_LOW_FILL}
                           : 32'h00000000;
      spiCnt_r   <= 6'h00;
    end
  end

  // per-attempt flags; a new event in the restart cycle is kept
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      iprogSeen_r <= 1'b0;
      wtoSeen_r   <= 1'b0;
    end else if (state_r == C_CLEAR) begin
      iprogSeen_r <= warm_r || (reprogCmd && fallback_r);
      wtoSeen_r   <= 1'b0;
    end else begin
      iprogSeen_r <= iprogSeen_r || (reprogCmd && fallback_r);
      wtoSeen_r   <= wtoSeen_r || wd.expired;
    end
  end

  always_comb begin
    entry                       = '0;
    entry[cfg_pkg::H_VALID]     = 1'b1;
    entry[cfg_pkg::H_FALLBACK]  = fallback_r;
    entry[cfg_pkg::H_REPROG]    = iprogSeen_r || (reprogCmd && fallback_r);
    entry[cfg_pkg::H_WTO]       = wtoSeen_r || wd.expired;
    entry[cfg_pkg::H_ID]        = idFault && state_r == C_LOAD;
    entry[cfg_pkg::H_CRC]       = crcFault && state_r == C_LOAD;
    entry[cfg_pkg::H_WRAP]      = wrapFault && state_r == C_LOAD;
  end

  // two-deep history: newest shifts into older on every outcome
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      history_r <= '0;
    end else if (record) begin
      history_r <= {history_r[cfg_pkg::ENTRY_W-1:0], entry};
    end
  end

  // watchdog: configuration monitor while loading, user monitor after
  assign wd.enable  = !wdLock_r && !fallback_r &&
                      ((timer_r[cfg_pkg::TMR_CFG_MON] && (state_r == C_APPLY ||
                        state_r == C_LOAD)) ||
                       (timer_r[cfg_pkg::TMR_USR_MON] && state_r == C_USER));
  assign wd.loadVal = timer_r[cfg_pkg::TMR_VAL_MSB:0];
  assign wd.reload  = (cmdWr && word[cfg_pkg::CMD_MSB:0] == cfg_pkg::CMD_RELOAD) ||
                      (dataWr && regAddr_r == cfg_pkg::REG_TIMER);

  wdog_timer wdTimer (
    .clk  (clk),
    .nrst (nrst),
    .wd   (wd.timer)
  );

  // pin drive
  assign loadStart    = (state_r == C_APPLY) && (!isSpi || spiCnt_r == cfg_pkg::SPI_CNT_LAST);
  assign initFlagPin  = (state_r != C_CLEAR) && (state_r != C_FAIL);
  assign doneOut      = (state_r == C_USER);
  assign spiAddrBit   = spiShift_r[cfg_pkg::SPI_BITS-1];
  assign spiAddrEn    = (state_r == C_APPLY) && isSpi;
  assign flashAddrOe  = isFlashPar && (state_r == C_APPLY || state_r == C_LOAD);
  assign flashAddrOut = warm_r ? warmAddr_r[cfg_pkg::START_MSB:0] : 29'h00000000;
  assign revSelOe     = (state_r == C_APPLY || state_r == C_LOAD) && !isSpi &&
                        (warm_r || (fallback_r && (isFlashPar ||
                                    mode_r == cfg_pkg::MODE_MPAR)));
  assign revSelOut    = warm_r ? warmAddr_r[cfg_pkg::RS_MSB:cfg_pkg::RS_LSB] : 2'h0;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  reprog_low_a: assert property (reprogTake |=> !initFlagPin && !doneOut)
    else $error("init or done not low after reprogram");
  init_release_a: assert property ((state_r == C_CLEAR && memCleared) |=> initFlagPin)
    else $error("init not released after clear");
  hist_shift_a: assert property (record |=>
    history_r[2*cfg_pkg::ENTRY_W-1:cfg_pkg::ENTRY_W] == $past(history_r[cfg_pkg::ENTRY_W-1:0]))
    else $error("history did not shift");
  expire_fallback_a: assert property ((wd.expired && !fallback_r) |=>
    fallback_r && state_r == C_CLEAR)
    else $error("no fallback after watchdog expiry");
  wd_locked_a: assert property (fallback_r |-> !wd.enable)
    else $error("watchdog enabled during fallback");
  skip_reprog_a: assert property ((reprogCmd && fallback_r && state_r == C_LOAD &&
    !loadFail) |=> state_r == C_LOAD)
    else $error("reprogram taken during fallback");
  spi_no_select_a: assert property (isSpi |-> !revSelOe)
    else $error("select driven in spi mode");
  fallback_select_a: assert property ((fallback_r && state_r == C_LOAD && isFlashPar) |->
    revSelOe && revSelOut == 2'h0)
    else $error("select not low during fallback");
  warm_write_a: assert property ((cfgWrite && pState_r == P_HDR &&
    word == 32'h30020001) ##1 (cfgWrite && !reprogTake) |=> warmAddr_r == $past(word))
    else $error("warm address not written");
  spi_frame_a: assert property ($fell(spiAddrEn) |-> $past(spiAddrEn, 32))
    else $error("spi address frame too short");

  reprog_c: cover property (reprogTake ##[1:1000] (state_r == C_USER));
  fallback_c: cover property (fallback_r && loadOk && state_r == C_LOAD);
  spi_c: cover property (spiAddrEn && spiCnt_r == cfg_pkg::SPI_CNT_LAST);
endmodule
`default_nettype wire

// file: src/wdog_if.sv
// watchdog control and expiry signals between controller and timer
`timescale 1ns/1ps
`default_nettype none
interface wdog_if;
  logic                         enable;
  logic [cfg_pkg::WDOG_W-1:0]   loadVal;
  logic                         reload;
  logic                         expired;
  modport ctrl  (output enable, output loadVal, output reload, input expired);
  modport timer (input enable, input loadVal, input reload, output expired);
endinterface
`default_nettype wire

// file: src/wdog_timer.sv
// 30-bit configuration watchdog with divided-oscillator tick
`timescale 1ns/1ps
`default_nettype none
module wdog_timer (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  wdog_if.timer    wd
);
  localparam logic [7:0] TICK_LAST = 8'(cfg_pkg::TICK_CYC - 1);

  logic [7:0]                 preCnt_r;
  logic                       tick;
  logic [cfg_pkg::WDOG_W-1:0] cnt_r;

  assign tick = (preCnt_r == TICK_LAST);

  // prescaler stands for the oscillator divided by 256
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      preCnt_r <= 8'h00;
    end else if (!wd.enable || tick) begin
      preCnt_r <= 8'h00;
    end else begin
      preCnt_r <= preCnt_r + 8'h01;
    end
  end

  // a disabled timer holds the load value so enabling starts a full count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (!wd.enable || wd.reload) begin
      cnt_r <= wd.loadVal;
    end else if (tick && cnt_r != '0) begin
      cnt_r <= cnt_r - 30'h00000001;
    end
  end

  assign wd.expired = wd.enable && !wd.reload && tick && (cnt_r == '0);

  tick_period_a: assert property (@(posedge clk) disable iff (!nrst)
    (wd.enable && tick) |=> (!tick) [*8])
    else $error("watchdog tick came too soon");
  expire_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    wd.expired |-> ($past(cnt_r) == '0 || cnt_r == '0))
    else $error("watchdog expired with count left");
endmodule
`default_nettype wire

// file: test/cfg_port_model.sv
// user-logic model driving the configuration word port
`timescale 1ns/1ps
`default_nettype none
module cfg_port_model (
  // clock
  input  wire logic        clk,
  // word port
  output logic             cfgWrite,
  output logic [31:0]      cfgWord,
  input  wire logic        rdValid,
  input  wire logic [31:0] rdData
);
  function automatic logic [31:0] swap(input logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      swap[i] = w[(i & ~7) + 7 - (i & 7)];
    end
  endfunction

  initial begin
    cfgWrite = 1'b0;
    cfgWord  = 32'h00000000;
  end

  task automatic put(input logic [31:0] w);
    @(negedge clk);
    cfgWrite = 1'b1;
    cfgWord  = swap(w);
  endtask

  // released word lines show the inverse so stale data is never taken as valid
  task automatic idle();
    @(negedge clk);
    cfgWrite = 1'b0;
    cfgWord  = ~cfgWord;
  endtask

  task automatic sync();
    put(32'hFFFFFFFF);
    put(cfg_pkg::SYNC_WORD);
  endtask

  task automatic reprog(input logic [31:0] addr);
    sync();
    put(32'h20000000);
    put(32'h30020001);
    put(addr);
    put(32'h30008001);
    put(32'h0000000F);
    put(32'h20000000);
    idle();
  endtask

  task automatic read_hist(output logic [31:0] d, output logic ok);
    ok = 1'b0;
    d  = 32'h00000000;
    sync();
    put(32'h2802C001);
    idle();
    for (int i = 0; i < 4; i++) begin
      if (!ok && rdValid === 1'b1) begin
        d  = swap(rdData);
        ok = 1'b1;
      end
      @(negedge clk);
    end
  endtask
endmodule
`default_nettype wire

// file: test/tb_warm_boot_reconfig_control.sv
// testbench for the warm-boot reconfiguration controller
`timescale 1ns/1ps
`default_nettype none
module tb_warm_boot_reconfig_control;
  logic        clk, nrst, cfgWrite, rdValid, memCleared, loadOk, crcFault, loadStart;
  logic        wrapFault, idFault;
  logic        initFlagPin, doneOut, revSelOe, flashAddrOe, spiAddrBit, spiAddrEn;
  logic [31:0] cfgWord, rdData;
  logic [2:0]  modePins;
  logic [1:0]  revSelOut;
  logic [28:0] flashAddrOut;
  int          err_total = 0;
  int          compares  = 0;

  cfg_port_model m (.clk(clk), .cfgWrite(cfgWrite), .cfgWord(cfgWord),
    .rdValid(rdValid), .rdData(rdData));

  warm_boot_reconfig_control dut (.clk(clk), .nrst(nrst), .cfgWrite(cfgWrite),
    .cfgWord(cfgWord), .rdValid(rdValid), .rdData(rdData), .modePins(modePins),
    .memCleared(memCleared), .loadOk(loadOk), .wrapFault(wrapFault), .crcFault(crcFault),
    .idFault(idFault), .loadStart(loadStart), .initFlagPin(initFlagPin),
    .doneOut(doneOut), .revSelOut(revSelOut), .revSelOe(revSelOe),
    .flashAddrOut(flashAddrOut), .flashAddrOe(flashAddrOe),
    .spiAddrBit(spiAddrBit), .spiAddrEn(spiAddrEn));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // k: 0 memory cleared, 1 load good, 2 checksum fault, 3 wrap and id faults
  task automatic ev(input logic [1:0] k);
    @(negedge clk);
    memCleared = (k == 2'h0);
    loadOk     = (k == 2'h1);
    crcFault   = (k == 2'h2);
    wrapFault  = (k == 2'h3);
    idFault    = (k == 2'h3);
    @(negedge clk);
    {memCleared, loadOk, crcFault, wrapFault, idFault} = 5'h00;
  endtask

  task automatic wait_load();
    int n;
    n = 0;
    while (loadStart !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 200) begin
        err_total++;
        wrap_up();
      end
    end
  endtask

  task automatic hist(input logic [15:0] exp);
    logic [31:0] d;
    logic        ok;
    m.read_hist(d, ok);
    chk(ok, 1'b1);
    chk(d[15:0], exp);
  endtask

  task automatic s_power_up();
    ev(2'h0);
    wait_load();
    ev(2'h1);
    chk(doneOut, 1'b1);
    hist(16'h0001);
  endtask

  task automatic s_warm();
    m.reprog(32'hC0123456);
    chk({initFlagPin, doneOut}, 2'h0);
    ev(2'h0);
    wait_load();
    chk(initFlagPin, 1'b1);
    chk({flashAddrOe, flashAddrOut}, {1'b1, 29'h0123456});
    chk({revSelOe, revSelOut}, 3'h7);
    ev(2'h1);
    hist(16'h0105);
  endtask

  task automatic s_fallback();
    m.reprog(32'h40000100);
    ev(2'h0);
    wait_load();
    ev(2'h2);
    chk(initFlagPin, 1'b0);
    ev(2'h0);
    wait_load();
    chk(flashAddrOut, 29'h0);
    chk({revSelOe, revSelOut}, 3'h4);
    m.reprog(32'h40000100);
    chk(initFlagPin, 1'b1);
    ev(2'h1);
    chk(doneOut, 1'b1);
    hist(16'h2507);
  endtask

  task automatic s_spi();
    logic [31:0] v;
    logic        st;
    int          n;
    v  = 32'h0;
    st = 1'b0;
    n  = 0;
    modePins = cfg_pkg::MODE_SPI;
    m.reprog(32'h00ABCDEF);
    @(negedge clk);
    memCleared = 1'b1;
    for (int i = 0; i < 60; i++) begin
      @(negedge clk);
      memCleared = 1'b0;
      if (spiAddrEn === 1'b1) begin
        v = {v[30:0], spiAddrBit};
        n++;
        if (n == 32) begin
          st = loadStart;
        end
      end
    end
    chk(n, 32);
    chk(v, 32'hABCDEFFF);
    chk(st, 1'b1);
    chk(revSelOe, 1'b0);
    ev(2'h1);
    chk(doneOut, 1'b1);
  endtask

  // timer value 1 in configuration monitor: expiry two ticks into the warm load
  task automatic s_wdog();
    int n;
    n = 0;
    m.sync();
    m.put(32'h30022001);
    m.put(32'h40000001);
    m.reprog(32'h00000200);
    ev(2'h0);
    while (initFlagPin !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > 500) begin
        err_total++;
        wrap_up();
      end
    end
    chk(n >= 300 && n <= 330, 1'b1);
    hist(16'h050D);
    ev(2'h0);
    wait_load();
    chk(revSelOe, 1'b0);
    ev(2'h3);
    chk(initFlagPin, 1'b0);
    hist(16'h0D53);
  endtask

  initial begin
    nrst       = 1'b0;
    modePins   = cfg_pkg::MODE_BPI;
    memCleared = 1'b0;
    loadOk     = 1'b0;
    crcFault   = 1'b0;
    wrapFault  = 1'b0;
    idFault    = 1'b0;
    repeat (3) @(negedge clk);
    chk({initFlagPin, doneOut, revSelOe, rdValid}, 4'h0);
    nrst = 1'b1;
    s_power_up();
    s_warm();
    s_fallback();
    s_spi();
    s_wdog();
    @(negedge clk);
    nrst = 1'b0;
    @(negedge clk);
    chk({initFlagPin, doneOut, revSelOe, rdValid}, 4'h0);
    nrst = 1'b1;
    hist(16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
